// [rtl/burst_order_pkg.sv]
/*
 Constants and types for the burst ordering and initial latency block.
 Assumes a single 200 MHz system clock; link pins are sampled, not clocked.
*/
package burst_order_pkg;
	// Plain register port map
	localparam logic [3:0] REG_CONFIG = 4'h0;
	localparam logic [3:0] REG_STATUS = 4'h4;
	localparam logic [3:0] REG_WORD_ADDR = 4'h8;

	// Configuration register zero layout and reset value
	localparam logic [15:0] CFG_RESET = 16'h8F2F;
	localparam int LAT_MSB = 7;
	localparam int LAT_LSB = 4;
	localparam int FIXED_BIT = 3;
	localparam int HYBRID_BIT = 2;
	localparam int WRAP_MSB = 1;
	localparam int WRAP_LSB = 0;

	// Command/address word layout
	localparam int CA_BYTES = 6;
	localparam int CA_READ_BIT = 47;
	localparam int CA_REG_BIT = 46;
	localparam int CA_BURST_TYPE_BIT = 45;
	localparam int CA_UPPER_MSB = 44;
	localparam int CA_UPPER_LSB = 16;
	localparam int CA_LOWER_MSB = 2;

	// Wrap length codes and word masks
	localparam logic [1:0] WRAP_128 = 2'h0;
	localparam logic [1:0] WRAP_64 = 2'h1;
	localparam logic [1:0] WRAP_16 = 2'h2;
	localparam logic [1:0] WRAP_32 = 2'h3;
	localparam logic [6:0] MASK_128 = 7'h3F;
	localparam logic [6:0] MASK_64 = 7'h1F;
	localparam logic [6:0] MASK_16 = 7'h07;
	localparam logic [6:0] MASK_32 = 7'h0F;

	// Latency codes
	localparam logic [3:0] LAT_CODE_3 = 4'hE;
	localparam logic [3:0] LAT_CODE_4 = 4'hF;
	localparam logic [3:0] LAT_CODE_5 = 4'h0;
	localparam logic [3:0] LAT_CODE_6 = 4'h1;
	localparam logic [3:0] LAT_CODE_7 = 4'h2;
	localparam logic [3:0] LAT_3 = 4'h3;
	localparam logic [3:0] LAT_4 = 4'h4;
	localparam logic [3:0] LAT_5 = 4'h5;
	localparam logic [3:0] LAT_6 = 4'h6;
	localparam logic [3:0] LAT_7 = 4'h7;

	typedef enum logic [1:0]
	{
		ST_IDLE = 2'b00,
		ST_CA = 2'b01,
		ST_LAT = 2'b10,
		ST_DATA = 2'b11
	} link_state_t;

	function automatic logic [3:0] latency_clocks(input logic [3:0] code);
		logic [3:0] clocks;
		clocks = LAT_7;
		case (code)
			LAT_CODE_3: clocks = LAT_3;
			LAT_CODE_4: clocks = LAT_4;
			LAT_CODE_5: clocks = LAT_5;
			LAT_CODE_6: clocks = LAT_6;
			LAT_CODE_7: clocks = LAT_7;
			default: clocks = LAT_7;
		endcase
		return clocks;
	endfunction
endpackage

// [rtl/burst_order_and_latency.sv]
/*
 Device-side burst address sequencing and initial latency for a self-refresh
 DRAM with an 8-bit DDR link. Link pins are asynchronous and sampled twice
 by clock; the array sits outside behind read/write address ports.
*/
`timescale 1ns/100ps
module burst_order_and_latency
	import burst_order_pkg::*;
(
	input wire logic clock,
	input wire logic rst,
	input wire logic [3:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_write,
	input wire logic reg_read,
	output logic [31:0] reg_rdata,
	input wire logic link_cs_n,
	input wire logic link_clk,
	input wire logic [7:0] link_dq_in,
	output logic [7:0] link_dq_out,
	output logic link_dq_oe,
	input wire logic rw_data_strobe_in,
	output logic rw_data_strobe_out,
	output logic rw_data_strobe_oe,
	input wire logic refresh_needed,
	output logic [31:0] array_read_addr,
	input wire logic [15:0] array_read_data,
	output logic array_read_strobe,
	output logic [31:0] array_write_addr,
	output logic [15:0] array_write_data,
	output logic [1:0] array_write_mask,
	output logic array_write_strobe
);
	link_state_t state_reg;
	link_state_t state_next;
	logic cs_meta, cs_sync;
	logic ck_meta, ck_sync, ck_prev;
	logic [7:0] dq_meta, dq_sync;
	logic mask_meta, mask_sync;
	logic [15:0] config_register_zero;
	logic [47:0] ca_reg;
	logic [2:0] ca_count_reg;
	logic double_reg;
	logic [4:0] lat_remaining_reg;
	logic [31:0] word_addr_reg;
	logic [31:0] group_base_reg;
	logic [6:0] words_done_reg;
	logic wrapped_once_reg;
	logic [15:0] word_hold_reg;
	logic [7:0] byte_hi_reg;
	logic mask_hi_reg;
	logic read_pending_reg;

	wire ck_rise = ck_sync & ~ck_prev;
	wire ck_fall = ~ck_sync & ck_prev;
	wire ck_edge = ck_rise | ck_fall;
	wire cs_active = ~cs_sync;
	wire [47:0] ca_shifted = {ca_reg[39:0], dq_sync};
	wire ca_done = (state_reg == ST_CA) && ck_edge && (ca_count_reg == 3'(CA_BYTES - 1));
	wire lat_exit = (state_reg == ST_LAT) && ck_rise && (lat_remaining_reg == 5'h00);
	wire data_rise = ((state_reg == ST_DATA) || lat_exit) && ck_rise;
	wire is_read = ca_reg[CA_READ_BIT];
	wire is_register = ca_reg[CA_REG_BIT];
	wire is_linear = ca_reg[CA_BURST_TYPE_BIT];
	wire new_is_read = ca_shifted[CA_READ_BIT];
	wire new_is_register = ca_shifted[CA_REG_BIT];
	wire [31:0] ca_word_addr = {ca_shifted[CA_UPPER_MSB:CA_UPPER_LSB], ca_shifted[CA_LOWER_MSB:0]};

	wire [1:0] wrap_length_field = config_register_zero[WRAP_MSB:WRAP_LSB];
	wire hybrid_order_select = config_register_zero[HYBRID_BIT];
	wire fixed_latency_enable = config_register_zero[FIXED_BIT];
	wire [3:0] initial_latency_field = config_register_zero[LAT_MSB:LAT_LSB];
	wire [3:0] lat_clocks = latency_clocks(initial_latency_field);
	wire [4:0] lat_total = double_reg ? {lat_clocks, 1'b0} : {1'b0, lat_clocks};

	// Word mask of the aligned wrap group
	wire [6:0] wrap_mask7 = (wrap_length_field == WRAP_128) ? MASK_128 :
		(wrap_length_field == WRAP_64) ? MASK_64 :
		(wrap_length_field == WRAP_16) ? MASK_16 : MASK_32;
	wire [31:0] wrap_mask = {25'h0000000, wrap_mask7};
	wire [31:0] linear_step = word_addr_reg + 32'h00000001;
	wire [31:0] wrap_step = (word_addr_reg & ~wrap_mask) | (linear_step & wrap_mask);
	wire [31:0] group_jump = group_base_reg + wrap_mask + 32'h00000001;
	wire hybrid_mode = ~is_linear & ~hybrid_order_select;
	wire last_of_group = (words_done_reg == wrap_mask7);
	wire [31:0] next_word_addr = is_linear ? linear_step :
		~hybrid_mode ? wrap_step :
		wrapped_once_reg ? linear_step :
		last_of_group ? group_jump : wrap_step;
	wire word_done = (state_reg == ST_DATA) && ck_fall;
	wire [15:0] read_source = is_register ? config_register_zero : array_read_data;
	wire link_cfg_write = word_done && is_register && ~is_read && (word_addr_reg[0] == 1'b0);

	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			cs_meta <= 1'b1;
			cs_sync <= 1'b1;
			ck_meta <= 1'b0;
			ck_sync <= 1'b0;
			ck_prev <= 1'b0;
			dq_meta <= 8'h00;
			dq_sync <= 8'h00;
			mask_meta <= 1'b0;
			mask_sync <= 1'b0;
		end
		else
		begin
			cs_meta <= link_cs_n;
			cs_sync <= cs_meta;
			ck_meta <= link_clk;
			ck_sync <= ck_meta;
			ck_prev <= ck_sync;
			dq_meta <= link_dq_in;
			dq_sync <= dq_meta;
			mask_meta <= rw_data_strobe_in;
			mask_sync <= mask_meta;
		end
	end

	always_comb
	begin
		state_next = state_reg;
		case (state_reg)
			ST_IDLE: if (cs_active) state_next = ST_CA;
			ST_CA:
				if (!cs_active) state_next = ST_IDLE;
				else if (ca_done) state_next = (new_is_register && !new_is_read) ? ST_DATA : ST_LAT;
			ST_LAT:
				if (!cs_active) state_next = ST_IDLE;
				else if (lat_exit) state_next = ST_DATA;
			ST_DATA: if (!cs_active) state_next = ST_IDLE;
			default: state_next = ST_IDLE;
		endcase
	end

	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			state_reg <= ST_IDLE;
			ca_reg <= 48'h000000000000;
			ca_count_reg <= 3'h0;
			double_reg <= 1'b0;
			lat_remaining_reg <= 5'h00;
		end
		else
		begin
			state_reg <= state_next;
			if (state_reg == ST_IDLE && cs_active)
			begin
				double_reg <= fixed_latency_enable | refresh_needed;
				ca_count_reg <= 3'h0;
			end
			if (state_reg == ST_CA && ck_edge)
			begin
				ca_reg <= ca_shifted;
				ca_count_reg <= ca_count_reg + 3'h1;
			end
			if (ca_done)
				lat_remaining_reg <= lat_total;
			else if (state_reg == ST_LAT && ck_rise && lat_remaining_reg != 5'h00)
				lat_remaining_reg <= lat_remaining_reg - 5'h01;
		end
	end

	// Burst address sequencing
	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			word_addr_reg <= 32'h00000000;
			group_base_reg <= 32'h00000000;
			words_done_reg <= 7'h00;
			wrapped_once_reg <= 1'b0;
		end
		else if (ca_done)
		begin
			word_addr_reg <= ca_word_addr;
			group_base_reg <= ca_word_addr & ~wrap_mask;
			words_done_reg <= 7'h00;
			wrapped_once_reg <= 1'b0;
		end
		else if (word_done)
		begin
			word_addr_reg <= next_word_addr;
			words_done_reg <= words_done_reg + 7'h01;
			if (hybrid_mode && last_of_group)
				wrapped_once_reg <= 1'b1;
		end
	end

	// Data phase: high byte on rising edge, low byte on falling edge
	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			link_dq_out <= 8'h00;
			link_dq_oe <= 1'b0;
			rw_data_strobe_out <= 1'b0;
			rw_data_strobe_oe <= 1'b0;
			word_hold_reg <= 16'h0000;
			byte_hi_reg <= 8'h00;
			mask_hi_reg <= 1'b0;
			read_pending_reg <= 1'b0;
		end
		else if (!cs_active)
		begin
			link_dq_oe <= 1'b0;
			rw_data_strobe_oe <= 1'b0;
			rw_data_strobe_out <= 1'b0;
			read_pending_reg <= 1'b0;
		end
		else if (state_reg == ST_IDLE || state_reg == ST_CA)
		begin
			rw_data_strobe_oe <= 1'b1;
			rw_data_strobe_out <= (state_reg == ST_IDLE) ? (fixed_latency_enable | refresh_needed) : double_reg;
			if (ca_done)
			begin
				rw_data_strobe_oe <= new_is_read;
				rw_data_strobe_out <= 1'b0;
				read_pending_reg <= new_is_read;
			end
		end
		else if (data_rise && read_pending_reg)
		begin
			word_hold_reg <= read_source;
			link_dq_out <= read_source[15:8];
			link_dq_oe <= 1'b1;
			rw_data_strobe_out <= 1'b1;
		end
		else if (state_reg == ST_DATA && read_pending_reg && ck_fall)
		begin
			link_dq_out <= word_hold_reg[7:0];
			rw_data_strobe_out <= 1'b0;
		end
		else if (data_rise)
		begin
			byte_hi_reg <= dq_sync;
			mask_hi_reg <= mask_sync;
		end
	end

	// Array strobes and configuration register
	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			array_read_strobe <= 1'b0;
			array_write_strobe <= 1'b0;
			array_write_addr <= 32'h00000000;
			array_write_data <= 16'h0000;
			array_write_mask <= 2'h0;
			config_register_zero <= CFG_RESET;
		end
		else
		begin
			array_read_strobe <= data_rise && cs_active && read_pending_reg && !is_register;
			array_write_strobe <= word_done && cs_active && !is_read && !is_register;
			if (word_done && !is_read)
			begin
				array_write_addr <= word_addr_reg;
				array_write_data <= {byte_hi_reg, dq_sync};
				array_write_mask <= {mask_hi_reg, mask_sync};
			end
			if (cs_active && link_cfg_write)
				config_register_zero <= {byte_hi_reg, dq_sync};
			else if (reg_write && reg_addr == REG_CONFIG)
				config_register_zero <= reg_wdata[15:0];
		end
	end

	assign array_read_addr = word_addr_reg;

	wire [31:0] read_mux = (reg_addr == REG_CONFIG) ? {16'h0000, config_register_zero} :
		(reg_addr == REG_STATUS) ? {16'h0000, wrapped_once_reg, double_reg, state_reg,
			lat_clocks, 1'b0, words_done_reg} :
		(reg_addr == REG_WORD_ADDR) ? word_addr_reg : 32'h00000000;

	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
			reg_rdata <= 32'h00000000;
		else if (reg_read)
			reg_rdata <= read_mux;
	end

	property p_ca_strobe_fixed;
		@(posedge clock) disable iff (rst)
		(state_reg == ST_CA && cs_active && fixed_latency_enable && double_reg && !ca_done) |=>
			rw_data_strobe_oe && rw_data_strobe_out;
	endproperty
	a_ca_strobe_fixed: assert property (p_ca_strobe_fixed) else $error("strobe not high in ca with fixed latency");

	property p_latency_load;
		@(posedge clock) disable iff (rst)
		(ca_done && !(new_is_register && !new_is_read) && cs_active) |=>
			lat_remaining_reg == (double_reg ? {lat_clocks, 1'b0} : {1'b0, lat_clocks});
	endproperty
	a_latency_load: assert property (p_latency_load) else $error("latency count loaded wrong");

	property p_latency_range;
		@(posedge clock) disable iff (rst)
		lat_clocks >= LAT_3 && lat_clocks <= LAT_7;
	endproperty
	a_latency_range: assert property (p_latency_range) else $error("latency clocks out of range");

	property p_reset_config;
		@(posedge clock) disable iff (rst)
		$fell(rst) |-> config_register_zero == CFG_RESET && lat_clocks == LAT_7;
	endproperty
	a_reset_config: assert property (p_reset_config) else $error("configuration not at reset value");

	property p_regwrite_zero_latency;
		@(posedge clock) disable iff (rst)
		(ca_done && new_is_register && !new_is_read && cs_active) |=> state_reg == ST_DATA;
	endproperty
	a_regwrite_zero_latency: assert property (p_regwrite_zero_latency) else $error("register write got latency");

	property p_legacy_wrap;
		@(posedge clock) disable iff (rst)
		(word_done && !is_linear && hybrid_order_select) |=>
			(word_addr_reg & ~wrap_mask) == ($past(word_addr_reg) & ~wrap_mask);
	endproperty
	a_legacy_wrap: assert property (p_legacy_wrap) else $error("legacy wrap left its group");

	property p_linear_step;
		@(posedge clock) disable iff (rst)
		(word_done && is_linear) |=> word_addr_reg == $past(word_addr_reg) + 32'h00000001;
	endproperty
	a_linear_step: assert property (p_linear_step) else $error("linear burst did not add one");

	property p_hybrid_jump;
		@(posedge clock) disable iff (rst)
		(word_done && hybrid_mode && !wrapped_once_reg && last_of_group) |=>
			wrapped_once_reg && word_addr_reg == group_base_reg + wrap_mask + 32'h00000001;
	endproperty
	a_hybrid_jump: assert property (p_hybrid_jump) else $error("hybrid did not move to next group");

	property p_hybrid_linear;
		@(posedge clock) disable iff (rst)
		(word_done && wrapped_once_reg) |=> word_addr_reg == $past(word_addr_reg) + 32'h00000001;
	endproperty
	a_hybrid_linear: assert property (p_hybrid_linear) else $error("hybrid tail not linear");
endmodule

// [bench/link_host_model.sv]
/*
 Host end of the link: chip select, link clock, command/address and write data.
 Assumes the bench resolves the shared data and strobe wires from both enables.
*/
`timescale 1ns/100ps
module link_host_model
(
	input wire logic clock,
	output logic link_cs_n,
	output logic link_clk,
	output logic [7:0] host_dq,
	output logic host_strobe,
	input wire logic [7:0] link_dq_out,
	input wire logic link_dq_oe,
	input wire logic rw_data_strobe_out,
	input wire logic rw_data_strobe_oe
);
	logic [15:0] words[$];
	logic [1:0] ca_strobe;
	int first_rise;
	initial
	begin
		link_cs_n = 1'b1;
		link_clk = 1'b0;
		host_dq = 8'h00;
		host_strobe = 1'b0;
	end
	// One link edge; 16 system clocks per half period
	task automatic link_edge(input logic [7:0] v, input logic m);
		host_dq <= v;
		host_strobe <= m;
		repeat (8) @(posedge clock);
		link_clk <= ~link_clk;
		repeat (8) @(posedge clock);
	endtask
	task automatic transfer(input logic [47:0] ca, input int nw, input int lat, input logic [15:0] wd,
		input logic [1:0] mk);
		int rises;
		logic [15:0] w;
		words.delete();
		first_rise = 0;
		link_cs_n <= 1'b0;
		repeat (8) @(posedge clock);
		for (int i = 5; i >= 0; i--)
		begin
			link_edge(ca[8 * i +: 8], ~host_strobe);
			if (i == 3)
				ca_strobe = {rw_data_strobe_oe, rw_data_strobe_out};
		end
		// Host waits out whatever latency the strobe announced
		rises = (ca[46] && !ca[47]) ? 0 : lat * (ca_strobe[0] ? 2 : 1);
		if (ca[47])
			for (int e = 1; e <= 2 * (nw + 16) && words.size() < nw; e++)
			begin
				link_edge(~host_dq, ~host_strobe);
				if (e % 2 == 1 && link_dq_oe === 1'b1 && first_rise == 0)
					first_rise = (e + 1) / 2;
				if (first_rise != 0 && e % 2 == 1)
					w[15:8] = link_dq_out;
				else if (first_rise != 0)
					words.push_back({w[15:8], link_dq_out});
			end
		else
		begin
			repeat (2 * rises) link_edge(~host_dq, ~host_strobe);
			for (int i = 0; i < nw; i++)
			begin
				w = wd + 16'(i);
				link_edge(w[15:8], mk[1]);
				link_edge(w[7:0], mk[0]);
			end
		end
		// Clock parks low, data released
		link_cs_n <= 1'b1;
		host_dq <= ~host_dq;
		repeat (16) @(posedge clock);
	endtask
endmodule

// [bench/burst_order_and_latency_tb.sv]
/*
 Self-checking bench: register port tasks, host link model, array model.
 Assumes the link runs far slower than the system clock.
*/
`timescale 1ns/100ps
module burst_order_and_latency_tb
	import burst_order_pkg::*;
;
	logic clock, rst, reg_write, reg_read, refresh_needed, host_strobe;
	logic link_cs_n, link_clk, link_dq_oe, rw_data_strobe_in, rw_data_strobe_out, rw_data_strobe_oe;
	logic array_read_strobe, array_write_strobe;
	logic [3:0] reg_addr;
	logic [31:0] reg_wdata, reg_rdata, array_read_addr, array_write_addr, seed, d;
	logic [15:0] array_read_data, array_write_data;
	logic [1:0] array_write_mask;
	logic [7:0] link_dq_in, link_dq_out, host_dq;
	logic [49:0] wq[$];
	int failures, n_tests, n_rd;
	logic [3:0] codes[5] = '{4'hE, 4'hF, 4'h0, 4'h1, 4'h2};
	logic [9:0] cases[6] = '{10'h003, 10'h06E, 10'h08C, 10'h0CA, 10'h16E, 10'h2C3};
	always #2.5 clock = ~clock;
	// Array word equals its own address, so read data reveal the order
	assign array_read_data = array_read_addr[15:0];
	assign link_dq_in = link_dq_oe ? link_dq_out : host_dq;
	assign rw_data_strobe_in = rw_data_strobe_oe ? rw_data_strobe_out : host_strobe;
	burst_order_and_latency dut_u (.clock, .rst, .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata,
		.link_cs_n, .link_clk, .link_dq_in, .link_dq_out, .link_dq_oe, .rw_data_strobe_in, .rw_data_strobe_out,
		.rw_data_strobe_oe, .refresh_needed, .array_read_addr, .array_read_data, .array_read_strobe,
		.array_write_addr, .array_write_data, .array_write_mask, .array_write_strobe);
	link_host_model host_u (.clock, .link_cs_n, .link_clk, .host_dq, .host_strobe, .link_dq_out, .link_dq_oe,
		.rw_data_strobe_out, .rw_data_strobe_oe);
	always @(posedge clock)
		if (array_write_strobe === 1'b1)
			wq.push_back({array_write_addr, array_write_data, array_write_mask});
	always @(posedge clock)
		if (array_read_strobe === 1'b1)
			n_rd++;
	function automatic logic [31:0] lfsr(input logic [31:0] v);
		return v[0] ? (v >> 1) ^ 32'h80200003 : v >> 1;
	endfunction
	function automatic logic [31:0] wmask(input logic [1:0] w);
		return (w == 2'h0) ? 32'h3F : (w == 2'h1) ? 32'h1F : (w == 2'h2) ? 32'h07 : 32'h0F;
	endfunction
	function automatic logic [31:0] exp_addr(input logic [31:0] s, input int i, input int mode,
		input logic [31:0] m);
		if (mode == 2)
			return s + 32'(i);
		if (mode == 0 && i > int'(m))
			return (s & ~m) + 32'(i);
		return (s & ~m) | ((s + 32'(i)) & m);
	endfunction
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp)
		begin
			failures++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic reg_wr(input logic [3:0] a, input logic [31:0] v);
		@(posedge clock);
		reg_addr <= a;
		reg_wdata <= v;
		reg_write <= 1'b1;
		@(posedge clock);
		reg_write <= 1'b0;
	endtask
	task automatic reg_rd(input logic [3:0] a, output logic [31:0] v);
		@(posedge clock);
		reg_addr <= a;
		reg_read <= 1'b1;
		@(posedge clock);
		reg_read <= 1'b0;
		#1 v = reg_rdata;
	endtask
	task automatic do_read(input logic [31:0] s, input int mode, input logic [31:0] m, input int lat,
		input logic fx);
		int nw;
		int rd0;
		logic st;
		nw = int'(m) + 5;
		st = fx | refresh_needed;
		rd0 = n_rd;
		host_u.transfer({1'b1, 1'b0, 1'(mode == 2), s[31:3], 13'h0, s[2:0]}, nw, lat, 16'h0, 2'b00);
		chk(host_u.ca_strobe, {1'b1, st});
		chk(host_u.first_rise, lat * (st ? 2 : 1) + 1);
		chk(host_u.words.size(), nw);
		chk(n_rd - rd0, nw);
		foreach (host_u.words[i])
			chk(host_u.words[i], exp_addr(s, i, mode, m) & 32'hFFFF);
	endtask
	task automatic give_verdict;
		if (failures == 0 && n_tests > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	initial
	begin
		repeat (100000) @(posedge clock);
		failures++;
		give_verdict();
	end
	initial
	begin
		logic [3:0] code;
		logic fx;
		int lat, mode;
		clock = 1'b0;
		rst = 1'b1;
		reg_addr = 4'h0;
		reg_wdata = 32'h0;
		reg_write = 1'b0;
		reg_read = 1'b0;
		refresh_needed = 1'b0;
		seed = 32'h0C5E;
		failures = 0;
		n_tests = 0;
		repeat (16) @(posedge clock);
		rst <= 1'b0;
		repeat (3) @(posedge clock);
		reg_rd(REG_CONFIG, d);
		chk(d, 32'h8F2F);
		reg_rd(REG_STATUS, d);
		chk(d[11:8], 4'h7);
		reg_wr(4'hC, 32'hFFFFFFFF);
		reg_rd(4'hC, d);
		chk(d, 32'h0);
		do_read({17'h0, seed[14:0]}, 1, 32'h0F, 7, 1'b1);
		// Hybrid 128/64/16/32, legacy 64, linear; every latency code
		for (int k = 0; k < 6; k++)
		begin
			seed = lfsr(seed);
			mode = int'(cases[k][9:8]);
			fx = seed[20];
			code = (k < 5) ? codes[k] : 4'(3 + seed % 11);
			lat = (k < 5) ? k + 3 : 7;
			refresh_needed <= seed[21];
			reg_wr(REG_CONFIG, {16'h0, 8'h8F, code, fx, 1'(mode == 1), cases[k][7:6]});
			reg_rd(REG_STATUS, d);
			chk(d[11:8], 4'(lat));
			// Start stays low so the burst keeps to one die
			do_read({17'h0, seed[14:6], cases[k][5:0]}, mode, wmask(cases[k][7:6]), lat, fx);
		end
		refresh_needed <= 1'b1;
		host_u.transfer({3'b010, 45'h0}, 1, 0, 16'h8FE1, 2'b00);
		chk(host_u.ca_strobe, 2'b11);
		reg_rd(REG_CONFIG, d);
		chk(d, 32'h8FE1);
		refresh_needed <= 1'b0;
		host_u.transfer({3'b110, 45'h0}, 1, 3, 16'h0, 2'b00);
		chk(host_u.ca_strobe, 2'b10);
		chk(host_u.first_rise, 4);
		chk(host_u.words[0], 16'h8FE1);
		refresh_needed <= 1'b1;
		seed = lfsr(seed);
		wq.delete();
		host_u.transfer({3'b000, 29'h7, 13'h0, 3'h6}, 3, 3, seed[15:0], 2'b01);
		chk(wq.size(), 3);
		foreach (wq[i])
		begin
			chk(wq[i][49:18], exp_addr(32'h3E, i, 0, 32'h1F));
			chk(wq[i][17:2], seed[15:0] + 16'(i));
			chk(wq[i][1:0], 2'b01);
		end
		give_verdict();
	end
endmodule
